// File: src/flash_sector_protection.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module flash_sector_protection #(
  parameter int         FLASH_BYTES = flash_guard_pkg::FLASH_BYTES_DEF,
  parameter bit         IS_ROM      = 1'b0,
  parameter bit         MASK_PROT   = 1'b0
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Mode and options
  input  wire flash_guard_pkg::prog_mode_e mode,
  input  wire logic [7:0]                 option_byte,
  // Cpu access
  input  wire flash_guard_pkg::cpu_req_s  req,
  // Results
  output logic [7:0]                      rd_data,
  output logic [7:0]                      flash_ctrl_status,
  output logic                            readout_protect,
  output logic                            op_done,
  output logic                            op_rejected
);

  localparam int AW = $clog2(FLASH_BYTES);
  localparam int SB = flash_guard_pkg::SECTOR_BYTES;
  localparam logic [15:0] TOP_MINUS1 = 16'(17'h10000 - 2 * SB);

  typedef enum logic [1:0] {guard_idle, guard_key1, guard_open} guard_e;

  guard_e                    register_access_guard;
  flash_guard_pkg::flash_op_s op;
  logic                      readout_protect_option_bit;
  logic                      erase_pending;
  logic [7:0]                array_q;
  logic                      rd_pending;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= flash_guard_pkg::SECTOR0_BASE) sector_of = 2'd0;
    else if (a >= TOP_MINUS1) sector_of = 2'd1;
    else sector_of = 2'd2;
  endfunction

  function automatic logic sector_exists(input logic [1:0] s);
    if (s == 2'd0) sector_exists = 1'b1;
    else if (s == 2'd1) sector_exists = FLASH_BYTES > SB;
    else sector_exists = FLASH_BYTES > 2 * SB;
  endfunction

  function automatic logic allowed(input logic [1:0] s,
                                   input flash_guard_pkg::prog_mode_e m);
    if (!sector_exists(s)) allowed = 1'b0;
    else if (m == flash_guard_pkg::mode_iap) allowed = s != 2'd0;
    else allowed = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Protection source: mask on rom, option bit otherwise
  logic next_prot;
  always_comb begin
    if (IS_ROM) next_prot = MASK_PROT;
    else next_prot = option_byte[flash_guard_pkg::OPT_READOUT_BIT];
  end

  // Removal launches a bulk erase before protection drops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readout_protect_option_bit <= 1'b0;
      erase_pending              <= 1'b0;
    end else if (erase_pending) begin
      erase_pending              <= 1'b0;
      readout_protect_option_bit <= 1'b0;
    end else if (readout_protect_option_bit && !next_prot && !IS_ROM) begin
      erase_pending <= 1'b1;
    end else begin
      readout_protect_option_bit <= next_prot;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) readout_protect <= 1'b0;
    else readout_protect <= readout_protect_option_bit;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register with key guard
  wire ctrl_wr = req.valid && req.write && req.addr == flash_guard_pkg::ADDR_CTRL_STATUS;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      register_access_guard <= guard_idle;
    end else if (ctrl_wr) begin
      case (register_access_guard)
        guard_idle: register_access_guard <= req.data == flash_guard_pkg::GUARD_KEY1 ?
                                             guard_key1 : guard_idle;
        guard_key1: register_access_guard <= req.data == flash_guard_pkg::GUARD_KEY2 ?
                                             guard_open : guard_idle;
        default:    register_access_guard <= guard_idle;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) flash_ctrl_status <= flash_guard_pkg::CTRL_RESET;
    else if (ctrl_wr && register_access_guard == guard_open)
      flash_ctrl_status <= req.data;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operation issue
  wire        arm    = flash_ctrl_status[flash_guard_pkg::CTRL_START_BIT];
  wire        flash_wr = req.valid && req.write && req.addr >= 16'(17'h10000 - FLASH_BYTES);
  wire [1:0]  tgt    = sector_of(req.addr);
  wire        bulk   = flash_ctrl_status[flash_guard_pkg::CTRL_BULK_BIT];
  wire        ok     = !readout_protect_option_bit && arm && register_access_guard == guard_open
                       && (bulk ? mode != flash_guard_pkg::mode_iap : allowed(tgt, mode));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op          <= '0;
      op_done     <= 1'b0;
      op_rejected <= 1'b0;
    end else begin
      op          <= '0;
      op_done     <= 1'b0;
      op_rejected <= 1'b0;
      if (erase_pending) begin
        op.valid   <= 1'b1;
        op.is_bulk <= 1'b1;
        op_done    <= 1'b1;
      end else if (flash_wr && ok) begin
        op.valid      <= 1'b1;
        op.is_program <= flash_ctrl_status[flash_guard_pkg::CTRL_PROG_BIT];
        op.is_sector  <= flash_ctrl_status[flash_guard_pkg::CTRL_SECT_BIT];
        op.is_bulk    <= bulk;
        op.sector     <= tgt;
        op.addr       <= req.addr;
        op.data       <= req.data;
        op_done       <= 1'b1;
      end else if (flash_wr) begin
        op_rejected <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reads: protected array reads as zero
  flash_array #(.FLASH_BYTES(FLASH_BYTES)) u_array (
    .clock   (clock),
    .op      (op),
    .rd_addr (req.addr[AW-1:0]),
    .rd_data (array_q)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) rd_pending <= 1'b0;
    else rd_pending <= req.valid && !req.write && !readout_protect_option_bit;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) rd_data <= 8'h00;
    else rd_data <= rd_pending ? array_q : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  guard_seq_a: assert property (@(posedge clock) disable iff (rst)
    op.valid && !$past(erase_pending) |-> $past(register_access_guard) == guard_open)
    else $error("Operation without open guard");
  iap_sector0_a: assert property (@(posedge clock) disable iff (rst)
    op.valid && !$past(erase_pending) && (op.is_bulk || op.sector == 2'd0)
    |-> $past(mode) != flash_guard_pkg::mode_iap)
    else $error("Sector 0 changed in application mode");
  prot_block_a: assert property (@(posedge clock) disable iff (rst)
    $past(readout_protect_option_bit) && !$past(erase_pending) |-> !op.valid)
    else $error("Write while protected");
  prot_read_a: assert property (@(posedge clock) disable iff (rst)
    $past(readout_protect_option_bit, 2) |-> rd_data == 8'h00)
    else $error("Read while protected");
  unprot_erase_a: assert property (@(posedge clock) disable iff (rst)
    erase_pending |=> op.valid && op.is_bulk ##1 !readout_protect_option_bit)
    else $error("Removal without erase");
  reject_a: assert property (@(posedge clock) disable iff (rst)
    op_rejected |-> !op.valid && $past(flash_wr)) else $error("Rejected request issued");
  rom_fixed_a: assert property (@(posedge clock) disable iff (rst)
    IS_ROM |-> !erase_pending) else $error("Rom protection changed");
  ctrl_reset_a: assert property (@(posedge clock)
    $fell(rst) |-> flash_ctrl_status == flash_guard_pkg::CTRL_RESET) else $error("Bad reset");
  sector_map_a: assert property (@(posedge clock) disable iff (rst)
    op.valid && !op.is_bulk && op.addr >= flash_guard_pkg::SECTOR0_BASE |-> op.sector == 2'd0)
    else $error("Sector map wrong");

  prog_c:   cover property (@(posedge clock) op.valid && op.is_program);
  sector_c: cover property (@(posedge clock) op.valid && op.is_sector);
  reject_c: cover property (@(posedge clock) op_rejected);
  unprot_c: cover property (@(posedge clock) erase_pending);

endmodule // flash_sector_protection

// File: src/flash_guard_pkg.sv
package flash_guard_pkg;

  // Address map
  localparam logic [15:0] ADDR_CTRL_STATUS = 16'h0024;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [15:0] SECTOR0_BASE     = 16'hf000;
  localparam logic [15:0] SECTOR1_BASE     = 16'he000;
  localparam int          SECTOR_BYTES     = 4096;
  localparam int          FLASH_BYTES_DEF  = 16384;

  // Control register fields
  localparam int CTRL_PROG_BIT  = 0;
  localparam int CTRL_SECT_BIT  = 1;
  localparam int CTRL_BULK_BIT  = 2;
  localparam int CTRL_START_BIT = 7;

  // Guard key sequence
  localparam logic [7:0] GUARD_KEY1 = 8'h56;
  localparam logic [7:0] GUARD_KEY2 = 8'hae;

  // Option byte bit that enables read-out protection
  localparam int OPT_READOUT_BIT = 7;

  typedef enum logic [1:0] {
    mode_tool,
    mode_icp,
    mode_iap
  } prog_mode_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } cpu_req_s;

  typedef struct packed {
    logic        valid;
    logic        is_program;
    logic        is_sector;
    logic        is_bulk;
    logic [1:0]  sector;
    logic [15:0] addr;
    logic [7:0]  data;
  } flash_op_s;

endpackage

// File: src/flash_array.sv
`timescale 1ns/10ps

// Flash array model: byte program, sector erase, bulk erase; erased = ff
module flash_array #(
  parameter int FLASH_BYTES = flash_guard_pkg::FLASH_BYTES_DEF,
  parameter int AW          = $clog2(FLASH_BYTES)
) (
  // Clock only, no reset
  input  wire logic                     clock,
  // Operation
  input  wire flash_guard_pkg::flash_op_s op,
  input  wire logic [AW-1:0]            rd_addr,
  // Read data
  output logic [7:0]                    rd_data
);

  localparam int SB = flash_guard_pkg::SECTOR_BYTES;

  logic [7:0] mem [FLASH_BYTES];

  function automatic logic [1:0] sector_of(input int idx);
    if (idx >= FLASH_BYTES - SB) sector_of = 2'd0;
    else if (idx >= FLASH_BYTES - 2 * SB) sector_of = 2'd1;
    else sector_of = 2'd2;
  endfunction

  always_ff @(posedge clock) begin
    for (int i = 0; i < FLASH_BYTES; i++) begin
      if (op.valid && op.is_bulk) begin
        mem[i] <= 8'hff;
      end else if (op.valid && op.is_sector && sector_of(i) == op.sector) begin
        mem[i] <= 8'hff; // Other sectors untouched
      end else if (op.valid && op.is_program && i == int'(op.addr[AW-1:0])) begin
        mem[i] <= mem[i] & op.data; // Byte program
      end
    end
  end

  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end

endmodule // flash_array

// File: test/prog_tool.sv
`timescale 1ns/10ps

// Programming controller model: owns mode and the request strobe
module prog_tool (
  // Clock
  input  wire logic                   clock,
  // Toward the device
  output flash_guard_pkg::prog_mode_e mode,
  output flash_guard_pkg::cpu_req_s   req
);
  initial begin
    mode = flash_guard_pkg::mode_tool;
    req  = '0;
  end

  // Released bus shows inverted fields, never the stale request
  task automatic send(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 req = '{1'b1, wr, a, d};
    @(posedge clock);
    #1 req = '{1'b0, ~wr, ~a, ~d};
  endtask

  task automatic unlock();
    send(1'b1, flash_guard_pkg::ADDR_CTRL_STATUS, flash_guard_pkg::GUARD_KEY1);
    send(1'b1, flash_guard_pkg::ADDR_CTRL_STATUS, flash_guard_pkg::GUARD_KEY2);
  endtask

  // Mode only changes between transfers
  task automatic enter(input flash_guard_pkg::prog_mode_e m);
    @(posedge clock);
    #1 mode = m;
  endtask
endmodule // prog_tool

// File: test/flash_sector_protection_test.sv
`timescale 1ns/10ps

module flash_sector_protection_test;
  logic                        clock;
  logic                        rst;
  logic [7:0]                  option_byte;
  flash_guard_pkg::prog_mode_e mode;
  flash_guard_pkg::cpu_req_s   req;
  logic [7:0]                  rd_data;
  logic [7:0]                  flash_ctrl_status;
  logic                        readout_protect;
  logic                        op_done;
  logic                        op_rejected;
  logic                        rom_protect;
  int                          miscompares = 0;
  int                          checked = 0;
  int                          cycles = 0;
  logic [15:0]                 lfsr = 16'h411e;
  logic [1:0]                  rd_pipe = 2'h0;
  logic [7:0]                  rd_q[$];
  logic                        op_q[$];
  logic [7:0]                  d1;
  logic [7:0]                  d2;

  prog_tool i_tool (.clock(clock), .mode(mode), .req(req));
  flash_sector_protection #(.FLASH_BYTES(16384)) i_dut (
    .clock(clock), .rst(rst), .mode(mode), .option_byte(option_byte), .req(req),
    .rd_data(rd_data), .flash_ctrl_status(flash_ctrl_status),
    .readout_protect(readout_protect), .op_done(op_done), .op_rejected(op_rejected));
  // Mask variant sees the same traffic; only its fixed protection is checked
  flash_sector_protection #(.FLASH_BYTES(4096), .IS_ROM(1'b1), .MASK_PROT(1'b1)) i_rom_dut (
    .clock(clock), .rst(rst), .mode(mode), .option_byte(option_byte), .req(req),
    .rd_data(), .flash_ctrl_status(), .readout_protect(rom_protect), .op_done(),
    .op_rejected());

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic compare(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic flash_wr(input logic [15:0] a, input logic [7:0] d, input logic ok);
    op_q.push_back(ok);
    i_tool.send(1'b1, a, d);
    repeat (3) @(posedge clock);
  endtask

  // Control write relocks the guard, so keys come twice
  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
                    input logic ok);
    // A plain 00 write relocks a guard left open by the previous operation
    i_tool.send(1'b1, flash_guard_pkg::ADDR_CTRL_STATUS, 8'h00);
    i_tool.unlock();
    i_tool.send(1'b1, flash_guard_pkg::ADDR_CTRL_STATUS, c);
    @(negedge clock);
    compare(flash_ctrl_status === c, "control register value");
    i_tool.unlock();
    flash_wr(a, d, ok);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    i_tool.send(1'b0, a, 8'h00);
    repeat (3) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Result watcher: reads land one edge after being taken
  always @(posedge clock) rd_pipe <= rst ? 2'h0 : {rd_pipe[0], req.valid & ~req.write};

  always @(negedge clock) begin
    if (rd_pipe[1])
      compare(rd_q.size() > 0 && rd_data === rd_q.pop_front(), "read data");
    if (op_done === 1'b1 || op_rejected === 1'b1)
      compare(op_q.size() > 0 && op_done === op_q.pop_front(), "operation outcome");
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    option_byte = 8'h00;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    @(negedge clock);
    compare(flash_ctrl_status === flash_guard_pkg::CTRL_RESET, "control reset");
    compare(readout_protect === 1'b0, "protection after reset");
    op(8'h84, 16'hc000, 8'h00, 1'b1);
    rd(16'hc000, 8'hff);
    rd(16'hffff, 8'hff);
    d1 = rnd();
    d2 = rnd();
    op(8'h81, 16'hf000, d1, 1'b1);
    op(8'h81, 16'hefff, d2, 1'b1);
    op(8'h81, 16'hdfff, d2 ^ 8'h3c, 1'b1);
    op(8'h81, 16'hefff, 8'h0f, 1'b1);
    rd(16'hefff, d2 & 8'h0f);
    // Sector 1 erase must spare its neighbours on both sides
    op(8'h82, 16'he800, 8'h00, 1'b1);
    rd(16'hefff, 8'hff);
    rd(16'hf000, d1);
    rd(16'hdfff, d2 ^ 8'h3c);
    // Armed control rewritten while open: guard drops, start bit stays
    i_tool.send(1'b1, flash_guard_pkg::ADDR_CTRL_STATUS, 8'h82);
    flash_wr(16'hdffe, 8'h00, 1'b0);
    rd(16'hdffe, 8'hff);
    i_tool.enter(flash_guard_pkg::mode_iap);
    op(8'h81, 16'hf001, 8'h00, 1'b0);
    op(8'h82, 16'hf000, 8'h00, 1'b0);
    op(8'h84, 16'hc000, 8'h00, 1'b0);
    rd(16'hf001, 8'hff);
    rd(16'hf000, d1);
    op(8'h81, 16'hc001, d1, 1'b1);
    rd(16'hc001, d1);
    i_tool.enter(flash_guard_pkg::mode_icp);
    op(8'h81, 16'hf002, d2, 1'b1);
    rd(16'hf002, d2);
    // Protection on, then removal with its forced erase
    @(posedge clock);
    #1 option_byte = 8'h80 | rnd();
    repeat (2) @(posedge clock);
    @(negedge clock);
    compare(readout_protect === 1'b1, "protection set");
    rd(16'hf000, 8'h00);
    op(8'h81, 16'hc002, 8'h00, 1'b0);
    // Removal issues its own bulk erase, reported like any operation
    op_q.push_back(1'b1);
    @(posedge clock);
    #1 option_byte = 8'h00;
    repeat (6) @(posedge clock);
    @(negedge clock);
    compare(readout_protect === 1'b0, "protection cleared");
    compare(rom_protect === 1'b1, "mask protection fixed");
    rd(16'hf000, 8'hff);
    rd(16'hc001, 8'hff);
    repeat (4) @(posedge clock);
    compare(op_q.size() == 0 && rd_q.size() == 0, "results outstanding");
    complete_run();
  end
endmodule // flash_sector_protection_test
